// >>> smc_regs.svh
// Register field positions, reset values and codes for the mode configuration
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
`define SMC_ADDR_W        14
`define SMC_DATA_W        16
`define SMC_LAT_LSB       4
`define SMC_LAT_MSB       6
`define SMC_WBS_BIT       9
`define SMC_OPM0_BIT      7
`define SMC_OPM1_BIT      8
`define SMC_OPM2_BIT      10
`define SMC_OPM3_BIT      11
`define SMC_TEMP_LSB      3
`define SMC_TEMP_MSB      4
`define SMC_COV_LSB       0
`define SMC_COV_MSB       2
`define SMC_BASE_RST      14'h0020
`define SMC_EXT_RST       14'h0018
`define SMC_LAT_MAX       3
`define SMC_CMD_LOAD      3'h0
`define SMC_CMD_READ      3'h5
`define SMC_CMD_WRITE     3'h4
`endif

// >>> smc_pkg.sv
// Types shared by the mode configuration block
package smc_pkg;
  typedef enum logic [1:0] {
    SMC_TEMP_70 = 2'b00,
    SMC_TEMP_45 = 2'b01,
    SMC_TEMP_15 = 2'b10,
    SMC_TEMP_85 = 2'b11
  } smc_temp_t;
  typedef enum logic [2:0] {
    SMC_COV_FULL    = 3'b000,
    SMC_COV_HALF    = 3'b001,
    SMC_COV_QUARTER = 3'b010
  } smc_cov_t;
  typedef struct packed {
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [1:0] bank;
    logic [13:0] addr;
  } smc_cmd_t;
  typedef struct packed {
    logic [1:0] latency;
    logic       lat_ok;
    logic       wr_single;
    logic       normal;
    logic [1:0] temp;
    logic [2:0] cov;
    logic       cov_ok;
  } smc_cfg_t;
endpackage

// >>> smc_lat_pipe.sv
// Read latency shift pipe: delays read data and drive enable
`timescale 1ns/100ps
`include "smc_regs.svh"
module smc_lat_pipe
  import smc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Launch side
  input  wire logic        rd_go,
  input  wire logic [15:0] rd_word,
  input  wire logic [1:0]  latency,
  // Pin side
  output logic             dq_drive,
  output logic [15:0]      dq_word
);
  logic [2:0]  vld_ff;
  logic [15:0] dat_ff [0:2];
  // Stage k holds data that appears at edge n+k+1
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_stage
      logic        nxt_v;
      logic [15:0] nxt_d;
      if (k == 0) begin : g_first
        assign nxt_v = rd_go;
        assign nxt_d = rd_word;
      end else begin : g_rest
        assign nxt_v = vld_ff[k-1];
        assign nxt_d = dat_ff[k-1];
      end
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          vld_ff[k] <= 1'b0;
          dat_ff[k] <= 16'h0000;
        end else if (clk_en) begin
          vld_ff[k] <= nxt_v;
          dat_ff[k] <= nxt_d;
        end
      end
    end
  endgenerate
  // Data valid at edge n+m; drive starts at edge n+m-1
  wire [1:0] sel_idx = latency - 2'h1;
  logic      drive_ff;
  logic [15:0] word_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_ff <= 1'b0;
      word_ff  <= 16'h0000;
    end else if (clk_en) begin
      drive_ff <= (sel_idx == 2'h0) ? rd_go : vld_ff[sel_idx - 2'h1];
      word_ff  <= (sel_idx == 2'h0) ? rd_word : dat_ff[sel_idx - 2'h1];
    end
  end
  // Drive and word launch together at edge n+m-1 and stand one cycle,
  // so the word is settled on the lines by edge n+m
  assign dq_word  = word_ff;
  assign dq_drive = drive_ff;
endmodule

// >>> smc_mode_cfg.sv
// Mode and extended mode registers with read latency data timing
//
// Functional notes
// - Read latency of 1, 2 or 3 cycles from read to data.
// - Read at edge n, latency m: data valid by edge n+m; the two input flops make it edge n+m+2 at the pins.
// - Data lines start driving from edge n+m-1; here they start from edge n+m+1 after the two input flops.
// - Write-burst-select clear: burst count applies to reads and writes.
// - Write-burst-select set: every write burst is single location.
// - Read bursts always keep programmed burst count.
// - Normal operation only when base bits 7, 8, 10, 11 are zero.
// - Extended bits 4:3 hold refresh temperature level encoding.
// - Extended bits 2:0 hold partial refresh coverage; others reserved.
// - Load writes base at banks 00, extended at bank1=1 bank0=0.
// - Read latency comes from base bits 6:4 at mode load.
`timescale 1ns/100ps
`include "smc_regs.svh"
module smc_mode_cfg
  import smc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Command pins from the controller
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  bank_sel,
  input  wire logic [13:0] addr,
  // Array side
  input  wire logic [15:0] array_rd_word,
  output logic             array_wr_single,
  // Data pins
  output logic [15:0]      dq_out,
  output logic             dq_oe_n,
  // Decoded configuration
  output smc_cfg_t         cfg
);
  // Pins come from another chip: two flops before use
  logic [20:0] cmd_s1_ff;
  logic [20:0] cmd_s2_ff;
  logic [15:0] rdw_s1_ff;
  logic [15:0] rdw_s2_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_s1_ff <= 21'h1fffff;
      cmd_s2_ff <= 21'h1fffff;
      rdw_s1_ff <= 16'h0000;
      rdw_s2_ff <= 16'h0000;
    end else if (clk_en) begin
      cmd_s1_ff <= {cs_n, ras_n, cas_n, we_n, bank_sel, addr, 1'b0};
      cmd_s2_ff <= cmd_s1_ff;
      rdw_s1_ff <= array_rd_word;
      rdw_s2_ff <= rdw_s1_ff;
    end
  end
  wire        sel_n  = cmd_s2_ff[20];
  smc_cmd_t   cmd;
  assign cmd = cmd_s2_ff[19:1];
  wire [2:0]  cmd_code = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  wire        is_load  = !sel_n && (cmd_code == `SMC_CMD_LOAD);
  wire        is_read  = !sel_n && (cmd_code == `SMC_CMD_READ);
  wire        is_write = !sel_n && (cmd_code == `SMC_CMD_WRITE);
  // Bank bits select which register a load writes
  wire        ld_base = is_load && (cmd.bank == 2'b00);
  wire        ld_ext  = is_load && (cmd.bank == 2'b10);
  logic [13:0] base_operating_config_ff;
  logic [13:0] extended_power_config_ff;
  wire [13:0] nxt_base = ld_base ? cmd.addr : base_operating_config_ff;
  wire [13:0] nxt_ext  = ld_ext ? cmd.addr : extended_power_config_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      base_operating_config_ff <= `SMC_BASE_RST;
      extended_power_config_ff <= `SMC_EXT_RST;
    end else if (clk_en) begin
      base_operating_config_ff <= nxt_base;
      extended_power_config_ff <= nxt_ext;
    end
  end
  // Latency field decode; reserved codes fall back to the slowest setting
  wire [2:0] lat_code = base_operating_config_ff[`SMC_LAT_MSB:`SMC_LAT_LSB];
  wire       lat_ok   = (lat_code >= 3'h1) && (lat_code <= 3'h3);
  wire [1:0] latency  = lat_ok ? lat_code[1:0] : 2'h3;
  wire       wbs      = base_operating_config_ff[`SMC_WBS_BIT];
  wire       normal   = !base_operating_config_ff[`SMC_OPM0_BIT] &&
                        !base_operating_config_ff[`SMC_OPM1_BIT] &&
                        !base_operating_config_ff[`SMC_OPM2_BIT] &&
                        !base_operating_config_ff[`SMC_OPM3_BIT];
  wire [2:0] cov_raw  =
    extended_power_config_ff[`SMC_COV_MSB:`SMC_COV_LSB];
  wire [1:0] temp_raw =
    extended_power_config_ff[`SMC_TEMP_MSB:`SMC_TEMP_LSB];
  wire       cov_ok   = (cov_raw == SMC_COV_FULL) ||
                        (cov_raw == SMC_COV_HALF) ||
                        (cov_raw == SMC_COV_QUARTER);
  // Reads unaffected by the write select; writes go single when it is set
  wire       rd_go    = is_read && normal;
  logic      wr_single_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_single_ff <= 1'b0;
    end else if (clk_en && is_write) begin
      wr_single_ff <= wbs;
    end
  end
  assign array_wr_single = wr_single_ff;
  logic     drive;
  smc_lat_pipe u_pipe (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .rd_go    (rd_go),
    .rd_word  (rdw_s2_ff),
    .latency  (latency),
    .dq_drive (drive),
    .dq_word  (dq_out)
  );
  assign dq_oe_n = !drive;
  // Configuration view from registers only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg <= '0;
    end else if (clk_en) begin
      cfg.latency   <= latency;
      cfg.lat_ok    <= lat_ok;
      cfg.wr_single <= wbs;
      cfg.normal    <= normal;
      cfg.temp      <= temp_raw;
      cfg.cov       <= cov_raw;
      cfg.cov_ok    <= cov_ok;
    end
  end
  // Data appears exactly latency cycles after the read reaches the core
  lat_two_a: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && rd_go && latency == 2'h2) ##1 clk_en |=> !dq_oe_n)
    else $error("Latency two drive missing");
  lat_three_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_go && latency == 2'h3 && clk_en) ##1 clk_en[*2] |=>
    !dq_oe_n)
    else $error("Latency three drive missing");
  base_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ld_base && clk_en) |=> base_operating_config_ff == $past(cmd.addr))
    else $error("Base register not loaded");
  ext_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ld_ext && clk_en) |=> extended_power_config_ff == $past(cmd.addr))
    else $error("Extended register not loaded");
  ext_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!ld_ext) |=> $stable(extended_power_config_ff))
    else $error("Extended register changed without load");
  test_block_a: assert property (@(posedge sys_clk) disable iff (rst)
    !normal |-> !rd_go)
    else $error("Read accepted outside normal mode");
  wr_single_a: assert property (@(posedge sys_clk) disable iff (rst)
    (is_write && wbs && clk_en) |=> array_wr_single)
    else $error("Write not single under write select");
  lat_code_a: assert property (@(posedge sys_clk) disable iff (rst)
    lat_ok |-> latency == lat_code[1:0])
    else $error("Latency decode wrong");
endmodule

// >>> smc_ctrl_model.sv
// Controller-side model that drives the command pins
`timescale 1ns/100ps
`include "smc_regs.svh"
module smc_ctrl_model
  import smc_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Command pins
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [1:0]       bank_sel,
  output logic [13:0]      addr
);
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    bank_sel = 2'h0;
    addr = 14'h0;
  end
  // One command for one cycle; released lines flip so stale values never pass
  task automatic issue(input logic [2:0] code, input logic [1:0] bank,
                       input logic [13:0] a);
    @(negedge sys_clk);
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = code;
    bank_sel = bank;
    addr = (bank == 2'h2) ? (a & 14'h001f) : a;
    @(negedge sys_clk);
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    bank_sel = ~bank;
    addr = ~a;
    // Loads only from idle, then a settle gap before the next command
    if (code == `SMC_CMD_LOAD)
      repeat (4) @(negedge sys_clk);
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the mode configuration block
`timescale 1ns/100ps
`include "smc_regs.svh"
module testbench;
  import smc_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic [15:0] array_rd_word;
  logic        cs_n, ras_n, cas_n, we_n;
  logic [1:0]  bank_sel;
  logic [13:0] addr;
  logic        array_wr_single;
  logic [15:0] dq_out;
  logic        dq_oe_n;
  smc_cfg_t    cfg;
  int          bad_count;
  int          n_tests;
  int          cycles;

  smc_ctrl_model u_ctrl (.sys_clk(sys_clk), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel), .addr(addr));
  // Clock enable tied high: the freeze path is not exercised here
  smc_mode_cfg u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_sel(bank_sel), .addr(addr), .array_rd_word(array_rd_word),
    .array_wr_single(array_wr_single), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .cfg(cfg));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Read, then watch the drive window and the data word cycle by cycle
  task automatic read_chk(input int m, input logic [15:0] w);
    array_rd_word = w;
    u_ctrl.issue(`SMC_CMD_READ, 2'h0, 14'h0);
    for (int k = 1; k <= m + 2; k++) begin
      @(negedge sys_clk);
      if (k == m) chk("oe_early", dq_oe_n, 16'h1);
      if (k == m + 1) chk("oe_start", dq_oe_n, 16'h0);
      if (k == m + 1) chk("dq_word", dq_out, w);
      if (k == m + 2) chk("oe_end", dq_oe_n, 16'h1);
    end
  endtask

  task automatic test_lat();
    for (int m = 1; m <= 3; m++) begin
      u_ctrl.issue(`SMC_CMD_LOAD, 2'h0, 14'(m << 4));
      chk("lat", cfg.latency, 16'(m));
      chk("lat_ok", cfg.lat_ok, 16'h1);
      read_chk(m, 16'h1230 + 16'(m));
    end
    for (int c = 4; c <= 8; c++) begin
      u_ctrl.issue(`SMC_CMD_LOAD, 2'h0, 14'((c % 8) << 4));
      chk("lat_rsv", cfg.lat_ok, 16'h0);
    end
  endtask

  task automatic test_wr();
    u_ctrl.issue(`SMC_CMD_LOAD, 2'h0, 14'h0220);
    chk("wr_cfg", cfg.wr_single, 16'h1);
    u_ctrl.issue(`SMC_CMD_WRITE, 2'h0, 14'h0);
    repeat (4) @(negedge sys_clk);
    chk("wr_one", array_wr_single, 16'h1);
    read_chk(2, 16'h5a5a);
    u_ctrl.issue(`SMC_CMD_LOAD, 2'h0, 14'h0020);
    u_ctrl.issue(`SMC_CMD_WRITE, 2'h0, 14'h0);
    repeat (4) @(negedge sys_clk);
    chk("wr_burst", array_wr_single, 16'h0);
  endtask

  task automatic test_opm();
    int b[4] = '{7, 8, 10, 11};
    foreach (b[i]) begin
      u_ctrl.issue(`SMC_CMD_LOAD, 2'h0, 14'h0020 | (14'h1 << b[i]));
      chk("normal", cfg.normal, 16'h0);
      u_ctrl.issue(`SMC_CMD_READ, 2'h0, 14'h0);
      for (int k = 0; k < 4; k++) begin
        @(negedge sys_clk);
        chk("oe_off", dq_oe_n, 16'h1);
      end
    end
    u_ctrl.issue(`SMC_CMD_LOAD, 2'h0, 14'h0020);
    chk("normal_on", cfg.normal, 16'h1);
  endtask

  task automatic test_ext();
    for (int v = 0; v < 32; v++) begin
      u_ctrl.issue(`SMC_CMD_LOAD, 2'h2, 14'(v));
      chk("temp", cfg.temp, 16'(v >> 3));
      chk("cov", cfg.cov, 16'(v % 8));
      chk("cov_ok", cfg.cov_ok, 16'(v % 8 < 3));
    end
    chk("base_kept", cfg.latency, 16'h2);
    u_ctrl.issue(`SMC_CMD_LOAD, 2'h1, 14'h0);
    u_ctrl.issue(`SMC_CMD_LOAD, 2'h3, 14'h0030);
    chk("ext_kept", cfg.temp, 16'h3);
    chk("lat_kept", cfg.latency, 16'h2);
  endtask

  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    rst = 1'b1;
    array_rd_word = 16'h0;
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    test_lat();
    test_wr();
    test_opm();
    test_ext();
    finish_test();
  end
endmodule
